/* verif/icu_pin_src.sv */
/*
 Far side of the capture unit: drives the capture pins and two timebases.
 Assumes the bench calls flip() from its own sequence on core_clk.
*/
`timescale 1ns/1ns
module icu_pin_src #(
    parameter int NCH = 4,
    parameter int TW = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    output logic [NCH-1:0] capPin,
    output logic [TW-1:0] firstTimebase,
    output logic [TW-1:0] secondTimebase
);
    logic [TW-1:0] cnt;

    // Second timebase is the inverse, so a wrong select shows at once
    assign firstTimebase = cnt;
    assign secondTimebase = ~cnt;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    initial capPin = '0;

    // =================================================================
    // Pin level held for two cycles; exp is the first timebase value
    // two cycles after the pin edge, the one the channel must latch
    task automatic flip(input int ch, output logic [TW-1:0] exp);
        @(posedge core_clk);
        capPin[ch] <= ~capPin[ch];
        exp = cnt + TW'(2);
        @(posedge core_clk);
    endtask
endmodule // icu_pin_src

/* verif/tb_top.sv */
/*
 Self-checking bench of the capture unit over Avalon-MM.
 Assumes icu_pin_src as the pin and timebase source.
*/
`timescale 1ns/1ns
`include "icu_params.svh"
module tb_top import icu_pkg::*; ;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [3:0] capPin;
    logic [15:0] firstTb;
    logic [15:0] secondTb;
    logic cpuIdle = 1'b0;
    logic cpuSleep = 1'b0;
    logic irq;
    int fails = 0;
    int nTests = 0;

    always #5 core_clk = ~core_clk;

    icu_top dut (.core_clk(core_clk), .rst(rst), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(4'h3),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .capPin(capPin), .firstTimebase(firstTb), .secondTimebase(secondTb),
        .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irq(irq));

    icu_pin_src src (.core_clk(core_clk), .rst(rst), .capPin(capPin),
        .firstTimebase(firstTb), .secondTimebase(secondTb));

    // =================================================================
    // Common tasks
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] seen,
                       input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", w, exp, seen);
        end
    endtask

    // Waitrequest and read data are taken at the rising edge that ends
    // the transfer, before that edge's own update lands
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWritedata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 20);
        if (avsWaitrequest !== 1'b0) begin
            fails++;
            stop_test();
        end
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string w);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(w, q, e);
    endtask

    task automatic pulse(input int ch, output logic [15:0] e);
        logic [15:0] x;
        src.flip(ch, e);
        src.flip(ch, x);
    endtask

    task automatic wait_irq(input logic lvl, input string w);
        int n;
        n = 0;
        while (irq !== lvl && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        chk(w, {31'h0, irq}, {31'h0, lvl});
        if (irq !== lvl) begin
            stop_test();
        end
    endtask

    function automatic logic [7:0] ca(input int ch);
        return 8'(ch * 16);
    endfunction

    // =================================================================
    // Scenarios
    task automatic t_reset();
        for (int ch = 0; ch < 4; ch++) begin
            rdchk(ca(ch), 32'h0, "ctrl reset");
        end
        rdchk(`ICU_ADR_STATUS, 32'h0, "status reset");
        rdchk(`ICU_ADR_MASK, 32'h0, "mask reset");
        rdchk(8'h50, 32'h0, "unmapped");
        chk("irq reset", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_rise();
        logic [15:0] e1, e2;
        wr(ca(0), 32'h0083);
        pulse(0, e1);
        pulse(0, e2);
        rdchk(ca(0), 32'h008b, "ctrl0 bne");
        rdchk(8'h04, {16'h0, e1}, "buf0 first");
        rdchk(8'h04, {16'h0, e2}, "buf0 second");
        rdchk(ca(0), 32'h0083, "ctrl0 empty");
        rdchk(8'h04, 32'h0, "buf0 empty");
        rdchk(`ICU_ADR_STATUS, 32'h1, "status0");
        rdchk(`ICU_ADR_STATUS, 32'h0, "status0 clr");
        wr(ca(0), 32'h0);
    endtask

    task automatic t_fall();
        logic [15:0] e;
        wr(ca(1), 32'h0002);
        src.flip(1, e);
        src.flip(1, e);
        rdchk(8'h14, {16'h0, ~e}, "buf1 fall");
        rdchk(8'h14, 32'h0, "buf1 no rise");
        rdchk(`ICU_ADR_STATUS, 32'h2, "status1");
        wr(ca(1), 32'h0);
    endtask

    task automatic t_both();
        logic [15:0] e1, e2;
        wr(`ICU_ADR_MASK, 32'h4);
        wr(ca(2), 32'h0061);
        src.flip(2, e1);
        wait_irq(1'b1, "irq both");
        rdchk(`ICU_ADR_STATUS, 32'h4, "status2 rise");
        wait_irq(1'b0, "irq clr");
        src.flip(2, e2);
        rdchk(`ICU_ADR_STATUS, 32'h4, "status2 fall");
        rdchk(8'h24, {16'h0, ~e1}, "buf2 rise");
        rdchk(8'h24, {16'h0, ~e2}, "buf2 fall");
        wr(`ICU_ADR_MASK, 32'h0);
        wr(ca(2), 32'h0);
    endtask

    // Every divider code; a control write restarts the count
    task automatic t_div();
        logic [15:0] e;
        logic [31:0] x;
        for (int d = 0; d < 4; d++) begin
            wr(ca(3), 32'h0003 | (32'(d) << 5));
            for (int k = 0; k <= d; k++) begin
                pulse(3, e);
                x = (k == d) ? 32'h8 : 32'h0;
                rdchk(`ICU_ADR_STATUS, x, "div");
            end
            wr(ca(3), 32'h0);
        end
    endtask

    task automatic t_presc();
        logic [15:0] e;
        logic [31:0] c;
        int n;
        for (int i = 0; i < 2; i++) begin
            n = i ? 16 : 4;
            c = i ? 32'h0085 : 32'h0084;
            wr(ca(0), c);
            repeat (n - 1) pulse(0, e);
            rdchk(ca(0), c, "presc idle");
            pulse(0, e);
            rdchk(8'h04, {16'h0, e}, "presc buf");
            wr(ca(0), 32'h0);
        end
        rdchk(`ICU_ADR_STATUS, 32'h1, "presc status");
    endtask

    task automatic t_ovf();
        logic [15:0] e [5];
        wr(ca(0), 32'h0003);
        for (int i = 0; i < 5; i++) pulse(0, e[i]);
        rdchk(ca(0), 32'h001b, "ovf set");
        for (int i = 0; i < 4; i++) begin
            rdchk(8'h04, {16'h0, ~e[i]}, "fifo");
        end
        rdchk(ca(0), 32'h0013, "ovf drained");
        wr(ca(0), 32'h0);
        rdchk(ca(0), 32'h0, "ovf off");
        wr(ca(0), 32'h0018);
        rdchk(ca(0), 32'h0, "ro bits");
        rdchk(`ICU_ADR_STATUS, 32'h1, "ovf status");
    endtask

    task automatic t_off();
        logic [15:0] e;
        logic [31:0] c;
        for (int i = 0; i < 2; i++) begin
            c = i ? 32'h0006 : 32'h0000;
            wr(ca(1), c);
            pulse(1, e);
            pulse(1, e);
            rdchk(ca(1), c, "off ctrl");
            rdchk(8'h14, 32'h0, "off buf");
        end
        rdchk(`ICU_ADR_STATUS, 32'h0, "off status");
        wr(ca(1), 32'h0);
    endtask

    task automatic t_wake();
        logic [15:0] e;
        wr(ca(2), 32'h20e7);
        pulse(2, e);
        rdchk(`ICU_ADR_STATUS, 32'h0, "wake awake");
        @(posedge core_clk);
        cpuSleep <= 1'b1;
        pulse(2, e);
        rdchk(ca(2), 32'h20e7, "wake no capture");
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdchk(`ICU_ADR_STATUS, 32'h4, "wake sleep");
        @(posedge core_clk);
        cpuSleep <= 1'b0;
        wr(ca(2), 32'h0);
    endtask

    task automatic t_sidl();
        logic [15:0] e;
        @(posedge core_clk);
        cpuIdle <= 1'b1;
        wr(ca(3), 32'h2003);
        pulse(3, e);
        rdchk(ca(3), 32'h2003, "idle halted");
        wr(ca(3), 32'h0003);
        pulse(3, e);
        rdchk(ca(3), 32'h000b, "idle runs");
        rdchk(8'h34, {16'h0, ~e}, "idle buf");
        @(posedge core_clk);
        cpuIdle <= 1'b0;
        wr(ca(3), 32'h0);
        rdchk(`ICU_ADR_STATUS, 32'h8, "idle status");
    endtask

    // =================================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_rise();
        t_fall();
        t_both();
        t_div();
        t_presc();
        t_ovf();
        t_off();
        t_wake();
        t_sidl();
        stop_test();
    end
endmodule // tb_top

/* verilog/icu_edge_detect.sv */
/*
 Edge detector and prescaler of one capture channel.
 Assumes the pin is already synchronous to core_clk.
*/
`timescale 1ns/1ns
`include "icu_params.svh"
module icu_edge_detect import icu_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    icu_evt_if.det ev
);

typedef struct packed {
    logic pinPrev;
    logic [3:0] presc;
    logic capEvt;
    logic wakeEvt;
} icu_det_t;

icu_det_t st_ff;
icu_det_t nxt_st;
logic rise;
logic fall;

assign rise = ev.pin & ~st_ff.pinPrev;
assign fall = ~ev.pin & st_ff.pinPrev;
assign ev.capEvt = st_ff.capEvt;
assign ev.wakeEvt = st_ff.wakeEvt;

// =====================================================================
// Edge selection
always_comb begin
    nxt_st = st_ff;
    nxt_st.pinPrev = ev.pin;
    nxt_st.capEvt = 1'b0;
    nxt_st.wakeEvt = 1'b0;
    if (ev.restart) begin
        // Reprogramming restarts the edge count from zero
        nxt_st.presc = 4'h0;
    end else if (ev.run) begin
        unique case (ev.mode)
            ICU_BOTH: nxt_st.capEvt = rise | fall;
            ICU_FALL: nxt_st.capEvt = fall;
            ICU_RISE: nxt_st.capEvt = rise;
            ICU_RISE4: begin
                if (rise) begin
                    nxt_st.capEvt = st_ff.presc == `ICU_PRESC4;
                    nxt_st.presc = nxt_st.capEvt ? 4'h0 :
                        4'(st_ff.presc + 4'h1);
                end
            end
            ICU_RISE16: begin
                if (rise) begin
                    nxt_st.capEvt = st_ff.presc == `ICU_PRESC16;
                    nxt_st.presc = 4'(st_ff.presc + 4'h1);
                end
            end
            ICU_WAKE: nxt_st.wakeEvt = rise;
            ICU_OFF: ;
            ICU_UNUSED: ;
        endcase
    end
end

always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
        st_ff <= '0;
    end else begin
        st_ff <= nxt_st;
    end
end

// =====================================================================
// Checks
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);

sequence s_rise_in(icu_mode_t m);
    ev.run && !ev.restart && ev.mode == m && rise;
endsequence

a_rise_every: assert property (s_rise_in(ICU_RISE) |=> ev.capEvt)
    else $error("rising edge not captured");
a_fall_every: assert property (
    ev.run && !ev.restart && ev.mode == ICU_FALL && fall |=> ev.capEvt
) else $error("falling edge not captured");
a_both_edges: assert property (
    ev.run && !ev.restart && ev.mode == ICU_BOTH && (rise || fall)
    |=> ev.capEvt) else $error("edge missed in both-edge mode");
a_off_quiet: assert property (ev.mode == ICU_OFF |=> !ev.capEvt)
    else $error("capture while off");
a_unused_quiet: assert property (
    ev.mode == ICU_UNUSED |=> !ev.capEvt && !ev.wakeEvt)
    else $error("activity in unused mode");
a_wake_only: assert property (s_rise_in(ICU_WAKE)
    |=> ev.wakeEvt && !ev.capEvt) else $error("wake edge mishandled");
a_presc_four: assert property (
    s_rise_in(ICU_RISE4) ##0 st_ff.presc != `ICU_PRESC4 |=> !ev.capEvt)
    else $error("early capture in divide-by-4");
a_presc_fourth: assert property (
    s_rise_in(ICU_RISE4) ##0 st_ff.presc == `ICU_PRESC4 |=> ev.capEvt)
    else $error("fourth edge not captured");
a_presc_16th: assert property (
    s_rise_in(ICU_RISE16) ##0 st_ff.presc == `ICU_PRESC16 |=> ev.capEvt)
    else $error("sixteenth edge not captured");

endmodule // icu_edge_detect

/* verilog/icu_evt_if.sv */
/*
 Per-channel link between the register core and its edge detector.
 Assumes both ends run on core_clk.
*/
`timescale 1ns/1ns
interface icu_evt_if;
    import icu_pkg::*;
    logic pin;
    icu_mode_t mode;
    logic run;
    logic restart;
    logic capEvt;
    logic wakeEvt;
    modport det (input pin, mode, run, restart, output capEvt, wakeEvt);
    modport core (output pin, mode, run, restart, input capEvt, wakeEvt);
endinterface

/* verilog/icu_params.svh */
/*
 Constants of the input capture unit: offsets, field positions,
 reset values and prescale counts. Definitions only.
*/
// =====================================================================
`ifndef ICU_PARAMS_SVH
`define ICU_PARAMS_SVH

// =====================================================================
// Register map (byte addresses)
`define ICU_OFS_CTRL 4'h0
`define ICU_OFS_BUF 4'h4
`define ICU_ADR_STATUS 8'h40
`define ICU_ADR_MASK 8'h44

// =====================================================================
// Control word fields
`define ICU_BIT_SIDL 13
`define ICU_BIT_TSEL 7
`define ICU_BIT_DIV 5
`define ICU_BIT_OVF 4
`define ICU_BIT_BNE 3
`define ICU_BIT_MODE 0
`define ICU_CTRL_WMASK 16'h20e7
`define ICU_CTRL_RST 16'h0000

// =====================================================================
// Prescale terminal counts
`define ICU_PRESC4 4'h3
`define ICU_PRESC16 4'hf

`endif

/* verilog/icu_pkg.sv */
/*
 Types shared by the input capture unit.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package icu_pkg;

// =====================================================================
// Capture mode field encodings
typedef enum logic [2:0] {
    ICU_OFF = 3'h0,
    ICU_BOTH = 3'h1,
    ICU_FALL = 3'h2,
    ICU_RISE = 3'h3,
    ICU_RISE4 = 3'h4,
    ICU_RISE16 = 3'h5,
    ICU_UNUSED = 3'h6,
    ICU_WAKE = 3'h7
} icu_mode_t;

endpackage

/* verilog/icu_top.sv */
/*
 Input capture unit: capture channels, their buffers, the interrupt
 status and mask, and an Avalon-MM slave with waitrequest.
 Assumes pins, timebases and the Idle/Sleep levels are synchronous to
 core_clk. DEPTH must be a power of two.
*/
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`include "icu_params.svh"
module icu_top import icu_pkg::*; #(
    parameter int NCH = 4,
    parameter int DEPTH = 4,
    parameter int TW = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NCH-1:0] capPin,
    input wire logic [TW-1:0] firstTimebase,
    input wire logic [TW-1:0] secondTimebase,
    input wire logic cpuIdle,
    input wire logic cpuSleep,
    output logic irq
);

localparam int PW = $clog2(DEPTH);
localparam int CW = $clog2(DEPTH + 1);
localparam logic [CW-1:0] FULL = CW'(DEPTH);
localparam logic [3:0] NCH4 = 4'(NCH);

// =====================================================================
// State
typedef struct packed {
    logic sidl;
    logic tsel;
    logic [1:0] div;
    icu_mode_t mode;
    logic ovf;
    logic [CW-1:0] cnt;
    logic [PW-1:0] rdp;
    logic [PW-1:0] wrp;
    logic [1:0] divCnt;
    logic [DEPTH-1:0][TW-1:0] mem;
} icu_chan_t;

typedef struct packed {
    icu_chan_t [NCH-1:0] ch;
    logic [NCH-1:0] sts;
    logic [NCH-1:0] mask;
    logic [NCH-1:0] stsSnap;
    logic ack;
    logic popOk;
    logic irqLine;
    logic [31:0] rdata;
} icu_top_t;

icu_top_t st_ff;
icu_top_t nxt_st;

logic busReq;
logic rdA;
logic rdB;
logic wrB;
logic [3:0] chIdx;
logic [3:0] regOfs;
logic chHit;
logic [NCH-1:0] evCap;
logic [NCH-1:0] evWake;
logic [NCH-1:0] stsSet;
logic [NCH-1:0] stsClr;

// =====================================================================
// Bus decode
// Phase A (waitrequest high) snapshots read data; phase B (waitrequest
// low) commits writes and read side effects. Costs one wait cycle but
// keeps readdata straight from a flop.
assign busReq = avs_read | avs_write;
assign avs_waitrequest = busReq & ~st_ff.ack;
assign rdA = avs_read & ~st_ff.ack;
assign rdB = avs_read & st_ff.ack;
assign wrB = avs_write & st_ff.ack;
assign chIdx = avs_address[7:4];
assign regOfs = avs_address[3:0];
assign chHit = chIdx < NCH4;
assign avs_readdata = st_ff.rdata;
assign irq = st_ff.irqLine;

function automatic logic [15:0] ctrlWord(input icu_chan_t c);
    logic [15:0] w;
    w = `ICU_CTRL_RST;
    w[`ICU_BIT_SIDL] = c.sidl;
    w[`ICU_BIT_TSEL] = c.tsel;
    w[`ICU_BIT_DIV +: 2] = c.div;
    w[`ICU_BIT_OVF] = c.ovf;
    w[`ICU_BIT_BNE] = c.cnt != '0;
    w[`ICU_BIT_MODE +: 3] = c.mode;
    return w;
endfunction

// =====================================================================
// Channels
genvar g;
generate
    for (g = 0; g < NCH; g++) begin : gChan
        icu_evt_if ev ();
        assign ev.pin = capPin[g];
        assign ev.mode = st_ff.ch[g].mode;
        // Wake mode ignores stop-in-idle and runs only while idle or asleep
        assign ev.run = (st_ff.ch[g].mode == ICU_WAKE) ?
            (cpuIdle | cpuSleep) :
            !(st_ff.ch[g].sidl && cpuIdle);
        assign ev.restart = wrB && chHit && chIdx == 4'(g) &&
            regOfs == `ICU_OFS_CTRL;
        assign evCap[g] = ev.capEvt;
        assign evWake[g] = ev.wakeEvt;
        icu_edge_detect uDet (
            .core_clk(core_clk),
            .rst(rst),
            .ev(ev.det)
        );
    end
endgenerate

// =====================================================================
// Next state
always_comb begin
    icu_chan_t c;
    logic push;
    logic pop;
    logic [15:0] m;
    logic [15:0] nw;
    c = '0;
    push = 1'b0;
    pop = 1'b0;
    m = '0;
    nw = '0;
    nxt_st = st_ff;
    stsSet = '0;
    stsClr = '0;
    nxt_st.ack = busReq & ~st_ff.ack;

    if (rdA) begin
        nxt_st.rdata = '0;
        nxt_st.popOk = 1'b0;
        nxt_st.stsSnap = '0;
        if (chHit) begin
            // Channel index, not buffer pointer width: NCH stays <= 4
            c = st_ff.ch[chIdx[1:0]];
            if (regOfs == `ICU_OFS_CTRL) begin
                nxt_st.rdata[15:0] = ctrlWord(c);
            end else if (regOfs == `ICU_OFS_BUF && c.cnt != '0) begin
                // Oldest entry first
                nxt_st.rdata[TW-1:0] = c.mem[c.rdp];
                nxt_st.popOk = 1'b1;
            end
        end else if (avs_address == `ICU_ADR_STATUS) begin
            nxt_st.rdata[NCH-1:0] = st_ff.sts;
            nxt_st.stsSnap = st_ff.sts;
        end else if (avs_address == `ICU_ADR_MASK) begin
            nxt_st.rdata[NCH-1:0] = st_ff.mask;
        end
    end

    for (int i = 0; i < NCH; i++) begin
        c = st_ff.ch[i];
        pop = rdB && chHit && chIdx == 4'(i) &&
            regOfs == `ICU_OFS_BUF && st_ff.popOk;
        push = 1'b0;
        if (evCap[i]) begin
            if (c.cnt != FULL || pop) begin
                push = 1'b1;
            end else begin
                // Full buffer keeps old data; the new value is lost
                c.ovf = 1'b1;
            end
            if (c.mode == ICU_BOTH || c.divCnt == c.div) begin
                stsSet[i] = 1'b1;
                c.divCnt = 2'h0;
            end else begin
                c.divCnt = 2'(c.divCnt + 2'h1);
            end
        end
        if (evWake[i]) begin
            stsSet[i] = 1'b1;
        end
        if (push) begin
            c.mem[c.wrp] = c.tsel ? firstTimebase :
                secondTimebase;
            c.wrp = PW'(c.wrp + 1'b1);
        end
        if (pop) begin
            c.rdp = PW'(c.rdp + 1'b1);
        end
        c.cnt = CW'(c.cnt + CW'(push) - CW'(pop));
        if (wrB && chHit && chIdx == 4'(i) && regOfs == `ICU_OFS_CTRL)
        begin
            // Status bits are outside the write mask
            m = `ICU_CTRL_WMASK &
                {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
            nw = (ctrlWord(c) & ~m) | (avs_writedata[15:0] & m);
            c.sidl = nw[`ICU_BIT_SIDL];
            c.tsel = nw[`ICU_BIT_TSEL];
            c.div = nw[`ICU_BIT_DIV +: 2];
            c.mode = icu_mode_t'(nw[`ICU_BIT_MODE +: 3]);
            c.divCnt = 2'h0;
            if (c.mode == ICU_OFF) begin
                c.cnt = '0;
                c.rdp = '0;
                c.wrp = '0;
                c.ovf = 1'b0;
            end
        end
        nxt_st.ch[i] = c;
    end

    if (wrB && avs_address == `ICU_ADR_MASK && avs_byteenable[0]) begin
        nxt_st.mask = avs_writedata[NCH-1:0];
    end
    // Read clears only what was reported; a new event still wins
    if (rdB && avs_address == `ICU_ADR_STATUS) begin
        stsClr = st_ff.stsSnap;
    end
    nxt_st.sts = (st_ff.sts & ~stsClr) | stsSet;
    nxt_st.irqLine = |(nxt_st.sts & nxt_st.mask);
end

always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
        st_ff <= '0;
    end else begin
        st_ff <= nxt_st;
    end
end

// =====================================================================
// Checks
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);

sequence s_ctrl0_read;
    rdA && chIdx == 4'h0 && regOfs == `ICU_OFS_CTRL;
endsequence

sequence s_cap0_room;
    evCap[0] && st_ff.ch[0].cnt != FULL && !wrB;
endsequence

a_bus_answer: assert property (busReq && !st_ff.ack |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
a_bne_read: assert property (s_ctrl0_read |=>
    avs_readdata[`ICU_BIT_BNE] == ($past(st_ff.ch[0].cnt) != '0))
    else $error("not-empty flag misreported");
a_tb_first: assert property (
    s_cap0_room ##0 st_ff.ch[0].tsel
    |=> st_ff.ch[0].mem[$past(st_ff.ch[0].wrp)] == $past(firstTimebase))
    else $error("wrong timebase captured");
a_cap_count: assert property (s_cap0_room ##0 !rdB
    |=> st_ff.ch[0].cnt == $past(st_ff.ch[0].cnt) + 1'b1)
    else $error("capture not stored");
a_ovf_full: assert property (
    evCap[0] && st_ff.ch[0].cnt == FULL && !rdB && !wrB
    |=> st_ff.ch[0].ovf) else $error("overflow not flagged");
a_off_flush: assert property (
    wrB && avs_address == 8'h00 && avs_byteenable[0] &&
    avs_writedata[2:0] == 3'h0 |=> st_ff.ch[0].cnt == '0 &&
    !st_ff.ch[0].ovf) else $error("mode off did not flush");
a_div_irq: assert property (
    evCap[0] && st_ff.ch[0].mode != ICU_BOTH &&
    st_ff.ch[0].divCnt != st_ff.ch[0].div && !evWake[0] && !rdB
    |=> st_ff.sts[0] == $past(st_ff.sts[0]))
    else $error("interrupt before divider count");
a_idle_halt: assert property (
    cpuIdle && st_ff.ch[0].sidl && st_ff.ch[0].mode != ICU_WAKE
    |=> !evCap[0]) else $error("capture while halted in idle");
a_irq_level: assert property (
    (st_ff.sts & st_ff.mask) != '0 |-> irq)
    else $error("interrupt output low with pending bit");

endmodule // icu_top
